// file: src/zcd_logic_irq.v
// Digital side of the zero-cross detector with edge flags and bus registers
//
// Overview of operation
// - Comparator high means sink, low means source
// - Output bit reads one while sinking
// - Inversion complements the logic output
// - Inversion acts even when detector disabled
// - Rise and fall detectors watch logic output
// - Enabled edge sets crossing event flag
// - Request needs flag and three enables
// - Inversion toggle may set the flag
// - Edge set wins over software clear
// - Enable forces pin output and output enable low, else GPIO drives them
// - Enable resets per configuration disable strap
// - Logic keeps working in sleep
//
// Local design decisions: the Avalon-MM slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "zcd_defines.vh"

module zcd_logic_irq
(
  input  wire        mclk,
  input  wire        rst_b,
  input  wire [3:0]  avsAddress,
  input  wire        avsRead,
  input  wire        avsWrite,
  input  wire [31:0] avsWriteData,
  input  wire [3:0]  avsByteEnable,
  output reg  [31:0] avsReadData,
  output wire        avsWaitRequest,
  input  wire        cmpSinkRaw,
  input  wire        porDefaultOff,
  input  wire        sleepMode,
  input  wire        gpioOut,
  input  wire        gpioOutEn,
  output wire        pinOut,
  output wire        pinOutEn,
  output wire        stageEnable,
  output wire        crossingLogicOutput,
  output wire        crossingIrq,
  output wire        irq
);

  // ==========================================================
  // Address decode shared by every register
  // ==========================================================
  function regHit;
    input [3:0] addr;
    input [3:0] ofs;
    begin
      regHit = (addr == ofs);
    end
  endfunction

  // ==========================================================
  // Bus handshake: one wait cycle per access
  // ==========================================================
  reg  ack_q;
  wire access;
  wire ack_d;
  wire take;
  wire wrTake;
  wire rdTake;
  wire ctrlWr;
  wire flagWr;
  wire ienWr;
  wire istRd;

  assign access         = avsRead | avsWrite;
  // Wait in the first cycle, answer in the second
  assign avsWaitRequest = access & ~ack_q;
  assign ack_d          = access & ~ack_q;
  assign take           = access & ack_q;
  // Writes need byte lane zero
  assign wrTake         = avsWrite & ack_q & avsByteEnable[0];
  assign rdTake         = avsRead & ack_q;
  assign ctrlWr         = wrTake & regHit(avsAddress, `ZCD_CTRL_OFS);
  assign flagWr         = wrTake & regHit(avsAddress, `ZCD_FLAG_OFS);
  assign ienWr          = wrTake & regHit(avsAddress, `ZCD_IRQEN_OFS);
  assign istRd          = rdTake & regHit(avsAddress, `ZCD_ISTAT_OFS);

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      ack_q <= 1'b0;
    else
      ack_q <= ack_d;
  end

  // ==========================================================
  // Synchroniser and strap capture
  // ==========================================================
  reg syncA_q;
  reg syncB_q;
  reg strapDone_q;
  reg enable_q;
  reg invert_q;
  reg riseEn_q;
  reg fallEn_q;
  reg [2:0] ien_q;
  reg flag_q;
  reg logicPrev_q;
  reg [`ZCD_IST_W-1:0] istat_q;
  reg [`ZCD_IST_W-1:0] imask_q;

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      syncA_q <= 1'b0;
      syncB_q <= 1'b0;
    end
    else
    begin
      syncA_q <= cmpSinkRaw;
      syncB_q <= syncA_q;
    end
  end

  // ==========================================================
  // Polarity and logic output
  // ==========================================================
  // sink decision after sync
  wire sinkActive = syncB_q;
  wire logicOut = sinkActive ^ invert_q;
  assign crossingLogicOutput = logicOut;

  // ==========================================================
  // Edge detection and flag, free of sleep gating
  // ==========================================================
  // no sleep term anywhere below
  wire unusedSleep = sleepMode;
  wire riseEdge = logicOut & ~logicPrev_q;
  wire fallEdge = ~logicOut & logicPrev_q;
  wire flagSet = (riseEdge & riseEn_q) | (fallEdge & fallEn_q);
  // Inversion change for the sticky status
  wire invEdge = ctrlWr & (avsWriteData[`ZCD_CTRL_INV_BIT] != invert_q);

  // Previous logic level for both detectors
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      logicPrev_q <= 1'b0;
    else
      logicPrev_q <= logicOut;
  end

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      flag_q <= 1'b0;
    else if (flagSet)
      flag_q <= 1'b1;
    else if (flagWr)
      flag_q <= avsWriteData[0];
  end

  // ==========================================================
  // Interrupt request
  // ==========================================================
  // request needs all enables
  assign crossingIrq = flag_q & ien_q[`ZCD_IEN_XING_BIT] &
                       ien_q[`ZCD_IEN_PERI_BIT] & ien_q[`ZCD_IEN_MAST_BIT];

  // ==========================================================
  // Control registers
  // ==========================================================
  // strap caught on first edge after reset
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      strapDone_q <= 1'b0;
      enable_q    <= 1'b0;
    end
    else if (!strapDone_q)
    begin
      strapDone_q <= 1'b1;
      enable_q    <= ~porDefaultOff;
    end
    else if (ctrlWr)
      enable_q <= avsWriteData[`ZCD_CTRL_EN_BIT];
  end

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      invert_q <= 1'b0;
    else if (ctrlWr)
      invert_q <= avsWriteData[`ZCD_CTRL_INV_BIT];
  end

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      riseEn_q <= 1'b0;
      fallEn_q <= 1'b0;
    end
    else if (ctrlWr)
    begin
      riseEn_q <= avsWriteData[`ZCD_CTRL_RISE_BIT];
      fallEn_q <= avsWriteData[`ZCD_CTRL_FALL_BIT];
    end
  end

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ien_q   <= `ZCD_IEN_RST;
      imask_q <= `ZCD_MASK_RST;
    end
    else if (ienWr)
    begin
      ien_q   <= avsWriteData[2:0];
      imask_q <= avsWriteData[9:8];
    end
  end

  // ==========================================================
  // Pin ownership
  // ==========================================================
  // enable selects pin owner
  assign stageEnable = enable_q;
  assign pinOut      = enable_q ? 1'b0 : gpioOut;
  assign pinOutEn    = enable_q ? 1'b0 : gpioOutEn;

  // ==========================================================
  // Sticky status, cleared by read; set wins
  // ==========================================================
  reg                   flagPrev_q;
  wire [`ZCD_IST_W-1:0] istSet;
  wire [`ZCD_IST_W-1:0] istHold;

  // Bit0 on request rise, bit1 on inversion change
  assign istSet  = {invEdge, crossingIrq & ~flagPrev_q};
  // Read clears, a same-cycle set still lands
  assign istHold = istRd ? {`ZCD_IST_W{1'b0}} : istat_q;

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      flagPrev_q <= 1'b0;
    else
      flagPrev_q <= crossingIrq;
  end

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      istat_q <= {`ZCD_IST_W{1'b0}};
    else
      istat_q <= istHold | istSet;
  end

  assign irq = |(istat_q & imask_q);

  // ==========================================================
  // Read data
  // ==========================================================
  reg [31:0] rdMux;

  always @*
  begin
    rdMux = 32'h00000000;
    case (avsAddress)
      `ZCD_CTRL_OFS:
        rdMux = {24'h000000, enable_q, 1'b0, logicOut, invert_q,
                 2'b00, riseEn_q, fallEn_q};
      `ZCD_FLAG_OFS:
        rdMux = {31'h00000000, flag_q};
      `ZCD_IRQEN_OFS:
        rdMux = {22'h000000, imask_q, 5'h00, ien_q};
      `ZCD_ISTAT_OFS:
        rdMux = {30'h00000000, istat_q};
      default:
        rdMux = 32'h00000000;
    endcase
  end

  // Captured in the wait cycle, stands at the answer edge
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      avsReadData <= 32'h00000000;
    else if (avsRead & ~ack_q)
      avsReadData <= rdMux;
  end

  wire unusedTake = take | unusedSleep | avsByteEnable[1];

endmodule
`default_nettype wire

// file: src/zcd_defines.vh
// Register offsets, field positions and reset values of the zero-cross detector
`ifndef ZCD_DEFINES_VH
`define ZCD_DEFINES_VH
// Word byte addresses on the Avalon-MM bus
`define ZCD_CTRL_OFS      4'h0
`define ZCD_FLAG_OFS      4'h4
`define ZCD_IRQEN_OFS     4'h8
`define ZCD_ISTAT_OFS     4'hC
// Control register fields
`define ZCD_CTRL_EN_BIT   7
`define ZCD_CTRL_OUT_BIT  5
`define ZCD_CTRL_INV_BIT  4
`define ZCD_CTRL_RISE_BIT 1
`define ZCD_CTRL_FALL_BIT 0
// Interrupt enable register fields
`define ZCD_IEN_XING_BIT  0
`define ZCD_IEN_PERI_BIT  1
`define ZCD_IEN_MAST_BIT  2
// Status bits of the sticky interrupt register
`define ZCD_IST_XING_BIT  0
`define ZCD_IST_INV_BIT   1
`define ZCD_IST_W         2
// Reset values
`define ZCD_CTRL_RST      8'h00
`define ZCD_IEN_RST       3'h0
`define ZCD_MASK_RST      2'h0
`endif

// file: bench/zcd_ac_source.sv
// AC source seen through the comparator
`timescale 1ns/100ps
`default_nettype none
module zcd_ac_source (
  input  wire logic vAbove,
  input  wire logic slow,
  output logic      cmpSinkRaw
);
  initial cmpSinkRaw = 1'b0;
  always @(vAbove) cmpSinkRaw <= #(slow ? 330 : 37) vAbove;
endmodule
`default_nettype wire

// file: bench/zcd_logic_irq_assertions.sv
// Port checker of the zero-cross block
`timescale 1ns/100ps
`default_nettype none
module zcd_logic_irq_assertions (
  input wire logic mclk, rst_b, avsRead, avsWrite, avsWaitRequest, cmpSinkRaw,
  input wire logic porDefaultOff, gpioOut, pinOut, pinOutEn, stageEnable,
  input wire logic crossingLogicOutput, crossingIrq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_pin_owned: assert property (stageEnable |-> !pinOut && !pinOutEn)
    else $error("pin kept");
  a_pin_pass: assert property (!stageEnable |-> pinOut == gpioOut)
    else $error("pin blocked");
  a_por_enable: assert property (
    !$past(rst_b, 2) && $past(rst_b) |-> stageEnable != $past(porDefaultOff))
    else $error("bad default");
  a_sync_edge: assert property (
    $changed(cmpSinkRaw) && !avsWrite ##1 !avsWrite [*2] |-> $changed(crossingLogicOutput))
    else $error("edge lost");
  a_out_cause: assert property (
    $changed(crossingLogicOutput) |-> $past(avsWrite) || !$past(rst_b, 3)
      || $past(cmpSinkRaw, 2) != $past(cmpSinkRaw, 3))
    else $error("stray output");
  a_flag_cause: assert property (
    $rose(crossingIrq) |-> $past(avsWrite)
      || $past(crossingLogicOutput) != $past(crossingLogicOutput, 2))
    else $error("stray request");
  a_flag_sticky: assert property ($fell(crossingIrq) |-> $past(avsWrite))
    else $error("flag dropped");
  a_bus_answer: assert property ((avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
    else $error("no answer");
  c_rise: cover property ($rose(crossingIrq));
  c_fall: cover property ($fell(crossingIrq));
  c_out: cover property ($changed(crossingLogicOutput) && !stageEnable);
endmodule
bind zcd_logic_irq zcd_logic_irq_assertions i_zcd_logic_irq_assertions (.*);
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench of the zero-cross block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        mclk = 1'b0, rst_b = 1'b0, avsRead = 1'b0, avsWrite = 1'b0, vAbove = 1'b0;
  logic        slow = 1'b0, gpioOut = 1'b1, porDefaultOff = 1'b0, sleepMode = 1'b1;
  logic        gpioOutEn = 1'b1;
  logic [3:0]  avsAddress = 4'h0, avsByteEnable = 4'hF;
  logic [31:0] avsWriteData = 32'h0, rdat;
  wire  [31:0] avsReadData;
  wire         avsWaitRequest, cmpSinkRaw, pinOut, pinOutEn, stageEnable;
  wire         crossingLogicOutput, crossingIrq, irq;
  int          fails = 0, n_checks = 0;
  zcd_ac_source i_zcd_ac_source (.*);
  zcd_logic_irq i_zcd_logic_irq (.*);
  initial forever #50 mclk = ~mclk;
  task automatic cyc(input int n); repeat (n) @(posedge mclk); endtask
  task automatic chk(input string n, input logic [31:0] e, s);
    n_checks++;
    if (s !== e)
    begin
      fails++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avsRead <= !w;
    avsWrite <= w;
    avsAddress <= a;
    avsWriteData <= d;
    do begin @(posedge mclk); k++; end while (avsWaitRequest !== 1'b0 && k < 20);
    if (avsWaitRequest !== 1'b0)
    begin
      fails++;
      end_of_test;
    end
    rdat = avsReadData;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d); bus(1'b1, a, d); endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rdat);
  endtask
  task automatic t_reset;
    chk("stage", 32'h1, stageEnable);
    chk("pin", 32'h0, {pinOutEn, pinOut});
    gpioOut <= 1'b0;
    wr(4'h0, 32'h0);
    chk("pin", 32'h2, {pinOutEn, pinOut});
    $display("reset test done");
  endtask
  task automatic t_pol;
    vAbove <= 1'b1;
    cyc(4);
    chk("logic", 32'h1, crossingLogicOutput);
    rdc(4'h0, 32'h20);
    wr(4'h0, 32'h10);
    rdc(4'h0, 32'h10);
    slow <= 1'b1;
    vAbove <= 1'b0;
    cyc(6);
    rdc(4'h0, 32'h30);
    $display("polarity test done");
  endtask
  task automatic t_edge;
    slow <= 1'b0;
    wr(4'h0, 32'h12);
    vAbove <= 1'b1;
    cyc(4);
    vAbove <= 1'b0;
    cyc(4);
    rdc(4'h4, 32'h1);
    wr(4'h4, 32'h0);
    wr(4'h0, 32'h02);
    rdc(4'h4, 32'h0);
    wr(4'h0, 32'h12);
    rdc(4'h4, 32'h1);
    wr(4'h4, 32'h0);
    wr(4'h0, 32'h01);
    rdc(4'h4, 32'h1);
    $display("edge test done");
  endtask
  task automatic t_irq;
    wr(4'h8, 32'h003);
    chk("xIrq", 32'h0, crossingIrq);
    wr(4'h8, 32'h007);
    chk("xIrq", 32'h1, crossingIrq);
    chk("irq", 32'h0, irq);
    wr(4'h8, 32'h307);
    chk("irq", 32'h1, irq);
    rdc(4'hC, 32'h3);
    chk("irq", 32'h0, irq);
    wr(4'h4, 32'h0);
    chk("xIrq", 32'h0, crossingIrq);
    rdc(4'h2, 32'h0);
    $display("irq test done");
  endtask
  task automatic t_strap;
    porDefaultOff <= 1'b1;
    rst_b <= 1'b0;
    cyc(2);
    chk("pin", 32'h2, {pinOutEn, pinOut});
    rst_b <= 1'b1;
    cyc(2);
    chk("stage", 32'h0, stageEnable);
    rdc(4'h0, 32'h00);
    rdc(4'h4, 32'h0);
    $display("strap test done");
  endtask
  initial
  begin
    cyc(2);
    rst_b <= 1'b1;
    cyc(2);
    t_reset;
    t_pol;
    t_edge;
    t_irq;
    t_strap;
    end_of_test;
  end
endmodule
`default_nettype wire
